// ### core/eeprom_port_pkg.sv
package eeprom_port_pkg;

    // ********************************************
    // I/O register locations
    // ********************************************
    localparam logic [5:0] IO_CONTROL = 6'h1c;
    localparam logic [5:0] IO_DATA = 6'h1d;
    localparam logic [5:0] IO_ADDRESS_LOW = 6'h1e;
    localparam logic [5:0] IO_ADDRESS_HIGH = 6'h1f;

    // ********************************************
    // Storage geometry
    // ********************************************
    localparam int STORE_BYTES = 512;
    localparam int ADDR_BITS = 9;
    localparam int ADDR_HIGH_BIT = 8;

    // ********************************************
    // Control register fields
    // ********************************************
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_WSTROBE_BIT = 1;
    localparam int CTRL_ARM_BIT = 2;

    // ********************************************
    // Timing
    // ********************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int ARM_WINDOW_CYCLES = 4;
    localparam int READ_STALL_CYCLES = 4;
    localparam int WRITE_STALL_CYCLES = 2;
    localparam int WRITE_TIME_US = 8500;
    localparam int WRITE_CYCLES_DEFAULT =
        (WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int WRITE_CNT_BITS = 17;

    localparam logic [2:0] ARM_LOAD = 3'(ARM_WINDOW_CYCLES);
    localparam logic [2:0] READ_STALL_LOAD = 3'(READ_STALL_CYCLES);
    localparam logic [2:0] WRITE_STALL_LOAD = 3'(WRITE_STALL_CYCLES);

    // ********************************************
    // Types
    // ********************************************
    typedef enum logic [0:0] {
        PHASE_IDLE = 1'b0,
        PHASE_WRITE = 1'b1
    } phase_t;

endpackage

// ### core/eeprom_byte_access_port.sv
// Overview of operation
// - 512 separate storage bytes, byte-wide access only
// - Addresses 0 to 511 select distinct bytes
// - Nine-bit address over high and low registers
// - Address bits 15..9 read as zero
// - Address loaded by software before any access
// - Write programs data byte at address
// - Read loads data register from address
// - Read stalls the CPU four cycles
// - Write start stalls the CPU two cycles
// - Self-timed write with readable busy bit
// - Write accepted only through protected arm sequence
// - All registers sit in I/O space
// - Control bits 7..4 read as zero
// - Arm clears after four cycles; strobe needs arm
// - Write strobe stays set until write done
// - Read strobe gives data next cycle
// - Busy write blocks reads and address changes
`timescale 1ns/1ps
`default_nettype none

module eeprom_byte_access_port
    import eeprom_port_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEFAULT
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,

    // I/O register port from the CPU core
    input wire logic [5:0] io_addr,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,

    // Pipeline hold towards the CPU core
    output logic cpu_stall
);

    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic [ADDR_BITS-1:0] address;
        logic [7:0] data;
        logic arm;
        logic [2:0] arm_cnt;
        phase_t phase;
        logic [WRITE_CNT_BITS-1:0] write_cnt;
        logic [2:0] stall_cnt;
        logic stall;
        logic [7:0] rdata;
    } state_t;

    localparam logic [WRITE_CNT_BITS-1:0] WRITE_LOAD =
        WRITE_CNT_BITS'(WRITE_CYCLES);

    state_t cur;
    state_t next_cur;

    // storage array, one byte per location
    logic [7:0] store [STORE_BYTES];

    // ********************************************
    // Decode
    // ********************************************
    logic wr_ctrl;
    logic wr_data;
    logic wr_low;
    logic wr_high;
    logic rd_sel;
    logic busy;
    logic start_write;
    logic start_read;
    logic [7:0] read_byte;
    logic [7:0] ctrl_view;

    // registers decoded from the I/O space
    assign wr_ctrl = io_we && (io_addr == IO_CONTROL);
    assign wr_data = io_we && (io_addr == IO_DATA);
    assign wr_low = io_we && (io_addr == IO_ADDRESS_LOW);
    assign wr_high = io_we && (io_addr == IO_ADDRESS_HIGH);
    assign rd_sel = io_re;

    assign busy = (cur.phase == PHASE_WRITE);

    assign start_write = wr_ctrl && io_wdata[CTRL_WSTROBE_BIT]
        && cur.arm && !busy;

    assign start_read = wr_ctrl && io_wdata[CTRL_READ_BIT] && !busy;

    assign read_byte = store[cur.address];

    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[CTRL_ARM_BIT] = cur.arm;
        ctrl_view[CTRL_WSTROBE_BIT] = busy;
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        next_cur = cur;

        // Arm window runs down on its own
        if (cur.arm) begin
            if (cur.arm_cnt <= 3'h1) begin
                next_cur.arm = 1'b0;
                next_cur.arm_cnt = 3'h0;
            end else begin
                next_cur.arm_cnt = cur.arm_cnt - 3'h1;
            end
        end

        // Write timer; strobe drops when it expires
        if (busy) begin
            if (cur.write_cnt <= WRITE_CNT_BITS'(1)) begin
                next_cur.phase = PHASE_IDLE;
                next_cur.write_cnt = '0;
            end else begin
                next_cur.write_cnt =
                    cur.write_cnt - WRITE_CNT_BITS'(1);
            end
        end

        // Stall counter towards the CPU
        if (cur.stall_cnt != 3'h0) begin
            next_cur.stall_cnt = cur.stall_cnt - 3'h1;
        end
        next_cur.stall = (next_cur.stall_cnt != 3'h0);

        // Address registers, frozen during a write
        // high bit and low byte
        if (wr_low && !busy) begin
            next_cur.address[7:0] = io_wdata;
        end
        if (wr_high && !busy) begin
            next_cur.address[ADDR_HIGH_BIT] = io_wdata[0];
        end

        // Data register from the CPU
        if (wr_data) begin
            next_cur.data = io_wdata;
        end

        // Control register
        if (wr_ctrl) begin
            // Arm on write; a strobe in the same write
            // sees the old arm, so one write can't do both
            if (io_wdata[CTRL_ARM_BIT] && !start_write) begin
                next_cur.arm = 1'b1;
                next_cur.arm_cnt = ARM_LOAD;
            end
            if (start_write) begin
                // arm used up by the write
                next_cur.arm = 1'b0;
                next_cur.arm_cnt = 3'h0;
                next_cur.phase = PHASE_WRITE;
                next_cur.write_cnt = WRITE_LOAD;
                next_cur.stall_cnt = WRITE_STALL_LOAD;
                next_cur.stall = 1'b1;
            end else if (start_read) begin
                next_cur.data = read_byte;
                next_cur.stall_cnt = READ_STALL_LOAD;
                next_cur.stall = 1'b1;
            end
        end

        // Read answer, one cycle after the request
        next_cur.rdata = 8'h00;
        if (rd_sel) begin
            case (io_addr)
                IO_CONTROL: begin
                    next_cur.rdata = ctrl_view;
                end
                IO_DATA: begin
                    next_cur.rdata = cur.data;
                end
                IO_ADDRESS_LOW: begin
                    next_cur.rdata = cur.address[7:0];
                end
                IO_ADDRESS_HIGH: begin
                    // bits above the ninth read zero
                    next_cur.rdata = {7'h00,
                        cur.address[ADDR_HIGH_BIT]};
                end
                default: begin
                    next_cur.rdata = 8'h00;
                end
            endcase
        end
    end

    // ********************************************
    // Registers
    // ********************************************
    // address known after reset
    // Address is cleared at reset for determinism;
    // software must still load it before use.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur.address <= '0;
            cur.data <= 8'h00;
            cur.arm <= 1'b0;
            cur.arm_cnt <= 3'h0;
            cur.phase <= PHASE_IDLE;
            cur.write_cnt <= '0;
            cur.stall_cnt <= 3'h0;
            cur.stall <= 1'b0;
            cur.rdata <= 8'h00;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // byte programmed at the held address
    // Data is taken at start, so later data writes
    // cannot corrupt the byte in flight.
    always_ff @(posedge core_clk) begin
        if (ce && !rst && start_write) begin
            store[cur.address] <= cur.data;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign io_rdata = cur.rdata;
    assign cpu_stall = cur.stall;

endmodule // eeprom_byte_access_port

`default_nettype wire

// ### verification/eeprom_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_port_checker
    import eeprom_port_pkg::*;
#(parameter int WRITE_CYCLES = 20) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [5:0] io_addr,
    input wire logic io_we,
    input wire logic io_re,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic cpu_stall
);
    logic [2:0] arm, stl;
    logic [16:0] bsy;
    logic cw, cr, busy, start, rgo;
    assign cw = ce && io_we && io_addr == IO_CONTROL;
    assign cr = ce && io_re && io_addr == IO_CONTROL;
    assign busy = bsy != 17'h0;
    assign start = cw && io_wdata[1] && arm != 3'h0 && !busy;
    assign rgo = cw && io_wdata[0] && !busy;
    // Reference timers; a write start wins over a read trigger
    // and uses up the arm window
    always_ff @(posedge core_clk) begin
        if (rst) begin
            arm <= 3'h0;
            stl <= 3'h0;
            bsy <= 17'h0;
        end else if (ce) begin
            arm <= start ? 3'h0 : (cw && io_wdata[2]) ? ARM_LOAD :
                arm - 3'(arm != 3'h0);
            stl <= start ? WRITE_STALL_LOAD :
                rgo ? READ_STALL_LOAD : stl - 3'(stl != 3'h0);
            bsy <= start ? 17'(WRITE_CYCLES) : bsy - 17'(busy);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    read_stall_a: assert property (rgo |=> cpu_stall [*4])
        else $error("read stall too short");
    write_stall_a: assert property (start |=> cpu_stall [*2])
        else $error("write stall too short");
    stall_length_a: assert property (cpu_stall == (stl != 3'h0))
        else $error("stall length wrong");
    idle_rdata_a: assert property (ce && !io_re |=> io_rdata == 8'h00)
        else $error("read data not idle");
    high_zero_a: assert property (ce && io_re &&
        io_addr == IO_ADDRESS_HIGH |=> io_rdata[7:1] == 7'h00)
        else $error("address high reserved bits set");
    ctrl_zero_a: assert property (cr |=>
        io_rdata[7:3] == 5'h00 && !io_rdata[0])
        else $error("control reserved bits set");
    busy_flag_a: assert property (cr |=> io_rdata[1] == $past(busy))
        else $error("write strobe flag wrong");
    arm_expiry_a: assert property (cw && io_wdata[2] ##1
        (!cw) [*4] ##1 (cr && !cw) |=> !io_rdata[2])
        else $error("arm did not expire");
    cover property (start);
    cover property (rgo);
    cover property (cr && busy);
endmodule // eeprom_port_checker
bind eeprom_byte_access_port eeprom_port_checker #(
    .WRITE_CYCLES(WRITE_CYCLES)) u_eeprom_port_checker (
    .core_clk(core_clk), .rst(rst), .ce(ce), .io_addr(io_addr),
    .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .cpu_stall(cpu_stall));
`default_nettype wire

// ### verification/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model
    import eeprom_port_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [5:0] io_addr,
    output logic io_we,
    output logic io_re,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial begin
        io_addr = 6'h00;
        io_we = 1'b0;
        io_re = 1'b0;
        io_wdata = 8'h00;
    end
    // Idle data flips so a stale byte is never mistaken for a write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_we = 1'b1;
        io_wdata = d;
        @(negedge core_clk);
        io_we = 1'b0;
        io_wdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        io_addr = a;
        io_re = 1'b1;
        @(negedge core_clk);
        io_re = 1'b0;
        d = io_rdata;
    endtask
    task automatic set_addr(input logic [8:0] a);
        wr(IO_ADDRESS_HIGH, {7'h00, a[8]});
        wr(IO_ADDRESS_LOW, a[7:0]);
    endtask
    task automatic wbyte(input logic [8:0] a, input logic [7:0] d);
        set_addr(a);
        wr(IO_DATA, d);
        wr(IO_CONTROL, 8'h04);
        wr(IO_CONTROL, 8'h02);
    endtask
    task automatic rbyte(input logic [8:0] a, output logic [7:0] d);
        set_addr(a);
        wr(IO_CONTROL, 8'h01);
        rd(IO_DATA, d);
    endtask
endmodule // cpu_model
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import eeprom_port_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, io_we, io_re, cpu_stall;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, d, mem [512];
    logic [8:0] aq [6];
    logic [31:0] rng = 32'd14743;
    int n_errors = 0, checks = 0;
    always #50 core_clk = ~core_clk;
    eeprom_byte_access_port #(.WRITE_CYCLES(20)) u_eeprom_byte_access_port (
        .core_clk(core_clk), .rst(rst), .ce(ce), .io_addr(io_addr),
        .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .cpu_stall(cpu_stall));
    cpu_model u_cpu_model (.core_clk(core_clk), .io_addr(io_addr),
        .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
        .io_rdata(io_rdata));
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic logic [7:0] high_exp(input logic [7:0] v);
        return {7'h00, v[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic ready();
        for (int i = 0; i < 40; i++) begin
            u_cpu_model.rd(IO_CONTROL, d);
            if (d[1] === 1'b0) return;
        end
        n_errors++;
        wrap_up();
    endtask
    initial begin
        #(3_000_000);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        u_cpu_model.wr(IO_ADDRESS_HIGH, 8'hff);
        u_cpu_model.rd(IO_ADDRESS_HIGH, d);
        chk(d, high_exp(8'hff));
        u_cpu_model.wr(IO_CONTROL, 8'hf0);
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d, 8'h00);
        // Arm left to lapse, then a late strobe
        u_cpu_model.wr(IO_CONTROL, 8'h04);
        repeat (4) @(negedge core_clk);
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d, 8'h00);
        u_cpu_model.wr(IO_CONTROL, 8'h02);
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            aq[i] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : xs() % 512;
            mem[aq[i]] = xs() % 256;
            u_cpu_model.wbyte(aq[i], mem[aq[i]]);
            ready();
        end
        // Unarmed strobe must leave storage alone
        u_cpu_model.wr(IO_DATA, ~mem[aq[0]]);
        u_cpu_model.wr(IO_CONTROL, 8'h02);
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d, 8'h00);
        mem[aq[1]] = xs() % 256;
        u_cpu_model.wbyte(aq[1], mem[aq[1]]);
        u_cpu_model.wr(IO_ADDRESS_LOW, ~aq[1][7:0]);
        u_cpu_model.wr(IO_CONTROL, 8'h01);
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d & 8'h02, 8'h02);
        u_cpu_model.rd(IO_ADDRESS_LOW, d);
        chk(d, aq[1][7:0]);
        // Clock enable low must freeze the write timer
        @(negedge core_clk);
        ce = 1'b0;
        repeat (30) @(negedge core_clk);
        ce = 1'b1;
        u_cpu_model.rd(IO_CONTROL, d);
        chk(d & 8'h02, 8'h02);
        ready();
        u_cpu_model.rd(IO_DATA, d);
        chk(d, mem[aq[1]]);
        for (int i = 0; i < 6; i++) begin
            u_cpu_model.rbyte(aq[i], d);
            chk(d, mem[aq[i]]);
        end
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
